// ===== crs_alu.sv
// arithmetic unit computing a result and its flag candidates
`timescale 1ns/1ns
module crs_alu (
	input wire crs_pkg::crs_op_type i_op,
	input wire logic [7:0] i_a,
	input wire logic [7:0] i_b,
	input wire logic i_carry_in,
	output logic [7:0] o_result,
	output logic [7:0] o_result_high,
	output logic o_nibble_carry,
	output logic o_carry
);
	logic [8:0] sum_w;
	logic [4:0] nib_w;
	logic [8:0] diff_w;
	logic [15:0] prod_w;
	logic cin_w;
	// add with optional carry; nibble sum reveals carry from bit 3 to bit 4
	assign cin_w = (i_op == crs_pkg::crs_op_adc) ? i_carry_in : 1'b0;
	assign sum_w = {1'b0, i_a} + {1'b0, i_b} + {8'h00, cin_w};
	assign nib_w = {1'b0, i_a[3:0]} + {1'b0, i_b[3:0]} + {4'h0, cin_w};
	assign diff_w = {1'b0, i_a} - {1'b0, i_b};
	assign prod_w = {8'h00, i_a} * {8'h00, i_b};
	always_comb begin
		o_result = i_b;
		o_result_high = 8'h00;
		o_nibble_carry = 1'b0;
		o_carry = i_carry_in;
		case (i_op)
			crs_pkg::crs_op_add, crs_pkg::crs_op_adc: begin
				o_result = sum_w[7:0];
				o_nibble_carry = nib_w[4];
				o_carry = sum_w[8];
			end
			crs_pkg::crs_op_sub: begin
				o_result = diff_w[7:0];
				o_carry = diff_w[8]; // borrow
			end
			crs_pkg::crs_op_logic: o_result = i_a & i_b;
			crs_pkg::crs_op_shift: begin
				o_result = {i_a[6:0], 1'b0};
				o_carry = i_a[7];
			end
			crs_pkg::crs_op_mul: begin
				o_result = prod_w[7:0];
				o_result_high = prod_w[15:8];
				o_carry = 1'b0;
			end
			default: o_result = i_b;
		endcase
	end
endmodule

// ===== crs_core_regs.sv
// architectural register set of the core: work, pointers, program counter, flags, stack pointer
//
// Contract
// - six core registers, not memory mapped, reached only through operation codes.
// - work register is 8 bits, source and sink of arithmetic and moves.
// - two 8-bit pointer registers for addressing and temporary data.
// - interrupt save and restore never touch pointer register two.
// - 16-bit program counter built from low and high byte registers.
// - flag layout 1,1,prio_high,nibble,prio_low,msb,null,overflow; reset 111x1xxx.
// - add and add-with-carry set nibble carry on bit 3 carry, else clear.
// - msb copy flag takes result bit 7 after data operations.
// - null result flag set when result is zero, else cleared.
// - overflow flag shows carry or borrow of last arithmetic operation.
// - set and clear carry force overflow flag; bit test, shifts update it.
// - priority encoding 10 level0, 01 level1, 00 level2, 11 level3 disabled.
// - interrupt entry loads priority bits from the source's level registers.
// - unmask, mask, return, halt, wait, push and pop write priority bits; here crs_op_push_flags leaves them unchanged.
// - flags pushed and popped whole; single bits tested and changed.
// - datapath supports 8 by 8 unsigned multiply.
// - stack pointer 16 bits, upper forced, reset 017f, wraps silently.
// - call uses two stack bytes, interrupt five, program counter low first.
`timescale 1ns/1ns
module crs_core_regs (
	input wire logic i_clock,
	input wire logic i_srst,
	input wire crs_pkg::crs_op_type i_op,
	input wire crs_pkg::crs_dst_type i_dst,
	input wire logic [7:0] i_operand_a,
	input wire logic [7:0] i_operand_b,
	input wire logic [1:0] i_irq_level,
	input wire logic i_pc_load,
	input wire logic [15:0] i_pc_next,
	input wire logic [2:0] i_flag_index,
	input wire logic i_flag_value,
	input wire logic [7:0] i_pop_data,
	output logic [7:0] o_work_reg,
	output logic [7:0] o_pointer_reg_one,
	output logic [7:0] o_pointer_reg_two,
	output logic [7:0] o_instr_ptr_low,
	output logic [7:0] o_instr_ptr_high,
	output logic [7:0] o_flags_register,
	output logic [15:0] o_stack_ptr,
	output logic [1:0] o_priority_level,
	output logic o_irq_disabled
);
	logic [7:0] work_q, work_d;
	logic [7:0] ptr1_q, ptr1_d;
	logic [7:0] ptr2_q, ptr2_d;
	logic [15:0] pc_q, pc_d;
	logic [7:0] flags_q, flags_d;
	logic [7:0] sp_low_q, sp_low_d;
	logic [7:0] mul_high_w;
	logic [7:0] alu_res_w;
	logic alu_nib_w;
	logic alu_carry_w;
	logic data_op_w;
	logic arith_op_w;
	logic [7:0] flag_bit_mask_w;
	logic flag_load_w;

	// one-hot mask of a single flag, used by bit write and bit test paths
	function automatic logic [7:0] crs_bit_mask(input logic [2:0] idx);
		crs_bit_mask = 8'h01 << idx;
	endfunction

	// stack pointer step with silent wrap inside the 128-byte window
	function automatic logic [7:0] crs_sp_step(input logic [7:0] sp, input logic [7:0] delta, input logic down);
		logic [7:0] t;
		t = down ? (sp - delta) : (sp + delta);
		crs_sp_step = t & crs_pkg::crs_sp_top;
	endfunction

	crs_alu u_alu (
		.i_op(i_op),
		.i_a(i_operand_a),
		.i_b(i_operand_b),
		.i_carry_in(flags_q[crs_pkg::crs_bit_overflow]),
		.o_result(alu_res_w),
		.o_result_high(mul_high_w),
		.o_nibble_carry(alu_nib_w),
		.o_carry(alu_carry_w)
	);

	// classify the operation for flag updates
	assign arith_op_w = (i_op == crs_pkg::crs_op_add) || (i_op == crs_pkg::crs_op_adc) ||
		(i_op == crs_pkg::crs_op_sub) || (i_op == crs_pkg::crs_op_mul);
	assign data_op_w = arith_op_w || (i_op == crs_pkg::crs_op_logic) ||
		(i_op == crs_pkg::crs_op_load) || (i_op == crs_pkg::crs_op_shift);
	assign flag_bit_mask_w = crs_bit_mask(i_flag_index);
	assign flag_load_w = (i_dst == crs_pkg::crs_dst_flags);

	// flag register next value; untouched bits hold
	always_comb begin
		flags_d = flags_q;
		if (i_op == crs_pkg::crs_op_add || i_op == crs_pkg::crs_op_adc) begin
			flags_d[crs_pkg::crs_bit_nibble_carry] = alu_nib_w;
		end
		if (data_op_w) begin
			flags_d[crs_pkg::crs_bit_msb_copy] = alu_res_w[7];
			flags_d[crs_pkg::crs_bit_null] = (alu_res_w == 8'h00);
		end
		case (i_op)
			crs_pkg::crs_op_add, crs_pkg::crs_op_adc, crs_pkg::crs_op_sub, crs_pkg::crs_op_mul,
			crs_pkg::crs_op_shift:
				flags_d[crs_pkg::crs_bit_overflow] = alu_carry_w;
			crs_pkg::crs_op_btjt:
				flags_d[crs_pkg::crs_bit_overflow] = |(i_operand_a & flag_bit_mask_w);
			crs_pkg::crs_op_set_carry: flags_d[crs_pkg::crs_bit_overflow] = 1'b1;
			crs_pkg::crs_op_clear_carry: flags_d[crs_pkg::crs_bit_overflow] = 1'b0;
			crs_pkg::crs_op_irq_entry, crs_pkg::crs_op_halt, crs_pkg::crs_op_wait_irq: begin
				// level registers of the serviced source; halt and wait also open interrupts
				flags_d[crs_pkg::crs_bit_prio_high] = (i_op == crs_pkg::crs_op_irq_entry) ?
					i_irq_level[1] : crs_pkg::crs_prio_level0[1];
				flags_d[crs_pkg::crs_bit_prio_low] = (i_op == crs_pkg::crs_op_irq_entry) ?
					i_irq_level[0] : crs_pkg::crs_prio_level0[0];
			end
			crs_pkg::crs_op_irq_unmask: begin
				flags_d[crs_pkg::crs_bit_prio_high] = crs_pkg::crs_prio_level0[1];
				flags_d[crs_pkg::crs_bit_prio_low] = crs_pkg::crs_prio_level0[0];
			end
			crs_pkg::crs_op_irq_mask: begin
				flags_d[crs_pkg::crs_bit_prio_high] = crs_pkg::crs_prio_level3[1];
				flags_d[crs_pkg::crs_bit_prio_low] = crs_pkg::crs_prio_level3[0];
			end
			crs_pkg::crs_op_pop_flags, crs_pkg::crs_op_irq_return:
				flags_d = i_pop_data; // whole register restored
			crs_pkg::crs_op_flag_write:
				flags_d = (flags_q & ~flag_bit_mask_w) | (i_flag_value ? flag_bit_mask_w : 8'h00);
			default: flags_d = flags_d;
		endcase
		if (flag_load_w) begin
			flags_d = alu_res_w; // direct load of the flag register
		end
		flags_d = flags_d | crs_pkg::crs_flags_fixed_ones; // top two bits always read 1
	end

	// work and pointer registers; pointer two is excluded from interrupt restore
	always_comb begin
		work_d = work_q;
		ptr1_d = ptr1_q;
		ptr2_d = ptr2_q;
		if (i_op == crs_pkg::crs_op_mul) begin
			ptr1_d = mul_high_w; // product high byte into pointer one, low into work
			work_d = alu_res_w;
		end else begin
			case (i_dst)
				crs_pkg::crs_dst_work: work_d = alu_res_w;
				crs_pkg::crs_dst_ptr1: ptr1_d = alu_res_w;
				crs_pkg::crs_dst_ptr2: ptr2_d = alu_res_w;
				default: work_d = work_q;
			endcase
		end
		if (i_op == crs_pkg::crs_op_irq_return) begin
			// return restores work and pointer one only; pointer two stays put
			work_d = i_operand_a;
			ptr1_d = i_operand_b;
		end
	end

	// program counter: loaded as a whole from the sequencer
	assign pc_d = i_pc_load ? i_pc_next : pc_q;

	// stack pointer low byte; frame sizes follow the operation
	always_comb begin
		case (i_op)
			crs_pkg::crs_op_call: sp_low_d = crs_sp_step(sp_low_q, 8'(crs_pkg::crs_call_frame_bytes), 1'b1);
			crs_pkg::crs_op_ret: sp_low_d = crs_sp_step(sp_low_q, 8'(crs_pkg::crs_call_frame_bytes), 1'b0);
			crs_pkg::crs_op_irq_entry: sp_low_d = crs_sp_step(sp_low_q, 8'(crs_pkg::crs_irq_frame_bytes), 1'b1);
			crs_pkg::crs_op_irq_return: sp_low_d = crs_sp_step(sp_low_q, 8'(crs_pkg::crs_irq_frame_bytes), 1'b0);
			crs_pkg::crs_op_push, crs_pkg::crs_op_push_flags: sp_low_d = crs_sp_step(sp_low_q, 8'h01, 1'b1);
			crs_pkg::crs_op_pop, crs_pkg::crs_op_pop_flags: sp_low_d = crs_sp_step(sp_low_q, 8'h01, 1'b0);
			crs_pkg::crs_op_reset_sp: sp_low_d = crs_pkg::crs_sp_top;
			default: sp_low_d = sp_low_q;
		endcase
	end

	// state registers, synchronous reset
	always_ff @(posedge i_clock) begin
		if (i_srst) begin
			work_q <= crs_pkg::crs_work_reset;
			ptr1_q <= crs_pkg::crs_ptr_reset;
			ptr2_q <= crs_pkg::crs_ptr_reset;
			pc_q <= crs_pkg::crs_pc_reset;
			flags_q <= crs_pkg::crs_flags_reset;
			sp_low_q <= crs_pkg::crs_sp_top;
		end else begin
			work_q <= work_d;
			ptr1_q <= ptr1_d;
			ptr2_q <= ptr2_d;
			pc_q <= pc_d;
			flags_q <= flags_d;
			sp_low_q <= sp_low_d;
		end
	end

	// outputs registered from the next-state values, so they change on the same edge as the state they mirror
	always_ff @(posedge i_clock) begin
		if (i_srst) begin
			o_work_reg <= crs_pkg::crs_work_reset;
			o_pointer_reg_one <= crs_pkg::crs_ptr_reset;
			o_pointer_reg_two <= crs_pkg::crs_ptr_reset;
			o_instr_ptr_low <= crs_pkg::crs_pc_reset[7:0];
			o_instr_ptr_high <= crs_pkg::crs_pc_reset[15:8];
			o_flags_register <= crs_pkg::crs_flags_reset;
			o_stack_ptr <= crs_pkg::crs_sp_reset;
			o_priority_level <= crs_pkg::crs_prio_level3;
			o_irq_disabled <= 1'b1;
		end else begin
			o_work_reg <= work_d;
			o_pointer_reg_one <= ptr1_d;
			o_pointer_reg_two <= ptr2_d;
			o_instr_ptr_low <= pc_d[7:0];
			o_instr_ptr_high <= pc_d[15:8];
			o_flags_register <= flags_d;
			o_stack_ptr <= {crs_pkg::crs_sp_high, sp_low_d}; // upper byte forced
			o_priority_level <= {flags_d[crs_pkg::crs_bit_prio_high], flags_d[crs_pkg::crs_bit_prio_low]};
			o_irq_disabled <= ({flags_d[crs_pkg::crs_bit_prio_high],
				flags_d[crs_pkg::crs_bit_prio_low]} == crs_pkg::crs_prio_level3);
		end
	end

	// checks
	property p_fixed_ones;
		@(posedge i_clock) disable iff (i_srst) o_flags_register[7:6] == 2'h3;
	endproperty
	a_fixed_ones: assert property (p_fixed_ones) else $error("flag top bits not one");
	property p_nibble;
		@(posedge i_clock) disable iff (i_srst) (i_op == crs_pkg::crs_op_add) |=>
			o_flags_register[4] == ($past(i_operand_a[3:0]) + $past(i_operand_b[3:0]) > 5'h0f);
	endproperty
	a_nibble: assert property (p_nibble) else $error("nibble carry wrong");
	property p_null;
		@(posedge i_clock) disable iff (i_srst) (data_op_w && i_dst == crs_pkg::crs_dst_work) |=>
			o_flags_register[1] == (o_work_reg == 8'h00);
	endproperty
	a_null: assert property (p_null) else $error("null flag mismatch");
	property p_msb;
		@(posedge i_clock) disable iff (i_srst) (data_op_w && i_dst == crs_pkg::crs_dst_work) |=>
			o_flags_register[2] == o_work_reg[7];
	endproperty
	a_msb: assert property (p_msb) else $error("msb flag mismatch");
	property p_set_carry;
		@(posedge i_clock) disable iff (i_srst)
			(i_op == crs_pkg::crs_op_set_carry && i_dst != crs_pkg::crs_dst_flags) |=> o_flags_register[0];
	endproperty
	a_set_carry: assert property (p_set_carry) else $error("carry not set");
	property p_ptr2_keep;
		@(posedge i_clock) disable iff (i_srst)
			(i_op == crs_pkg::crs_op_irq_return || i_op == crs_pkg::crs_op_irq_entry) |=> $stable(o_pointer_reg_two);
	endproperty
	a_ptr2_keep: assert property (p_ptr2_keep) else $error("pointer two disturbed");
	property p_entry_level;
		@(posedge i_clock) disable iff (i_srst)
			(i_op == crs_pkg::crs_op_irq_entry && i_dst != crs_pkg::crs_dst_flags) |=> o_priority_level == $past(i_irq_level);
	endproperty
	a_entry_level: assert property (p_entry_level) else $error("entry level not loaded");
	property p_disable;
		@(posedge i_clock) disable iff (i_srst) o_irq_disabled == (o_priority_level == 2'h3);
	endproperty
	a_disable: assert property (p_disable) else $error("disable flag mismatch");
	property p_sp_high;
		@(posedge i_clock) disable iff (i_srst) o_stack_ptr[15:7] == 9'h002;
	endproperty
	a_sp_high: assert property (p_sp_high) else $error("stack pointer out of window");
	property p_irq_frame;
		@(posedge i_clock) disable iff (i_srst) (i_op == crs_pkg::crs_op_irq_entry) |=>
			o_stack_ptr[6:0] == 7'($past(o_stack_ptr[6:0]) - 7'h05);
	endproperty
	a_irq_frame: assert property (p_irq_frame) else $error("interrupt frame size wrong");
	// carries, priority writes, stack steps and program counter
	property p_add_carry;
		@(posedge i_clock) disable iff (i_srst) (i_op == crs_pkg::crs_op_add && !flag_load_w) |=>
			o_flags_register[0] == (({1'b0, $past(i_operand_a)} + {1'b0, $past(i_operand_b)}) > 9'h0ff);
	endproperty
	a_add_carry: assert property (p_add_carry) else $error("add carry wrong");
	property p_sub_borrow;
		@(posedge i_clock) disable iff (i_srst) (i_op == crs_pkg::crs_op_sub && !flag_load_w) |=>
			o_flags_register[0] == ($past(i_operand_b) > $past(i_operand_a));
	endproperty
	a_sub_borrow: assert property (p_sub_borrow) else $error("subtract borrow wrong");
	property p_clear_carry;
		@(posedge i_clock) disable iff (i_srst)
			(i_op == crs_pkg::crs_op_clear_carry && !flag_load_w) |=> !o_flags_register[0];
	endproperty
	a_clear_carry: assert property (p_clear_carry) else $error("carry not cleared");
	property p_unmask;
		@(posedge i_clock) disable iff (i_srst) (i_op == crs_pkg::crs_op_irq_unmask && !flag_load_w) |=>
			o_priority_level == 2'h2 && !o_irq_disabled;
	endproperty
	a_unmask: assert property (p_unmask) else $error("unmask level wrong");
	property p_mask;
		@(posedge i_clock) disable iff (i_srst) (i_op == crs_pkg::crs_op_irq_mask && !flag_load_w) |=>
			o_priority_level == 2'h3 && o_irq_disabled;
	endproperty
	a_mask: assert property (p_mask) else $error("mask level wrong");
	property p_pop_flags;
		@(posedge i_clock) disable iff (i_srst) (i_op == crs_pkg::crs_op_pop_flags && !flag_load_w) |=>
			o_flags_register == ($past(i_pop_data) | 8'hc0);
	endproperty
	a_pop_flags: assert property (p_pop_flags) else $error("popped flags wrong");
	property p_mul;
		@(posedge i_clock) disable iff (i_srst) (i_op == crs_pkg::crs_op_mul) |=>
			{o_pointer_reg_one, o_work_reg} == ({8'h00, $past(i_operand_a)} * {8'h00, $past(i_operand_b)});
	endproperty
	a_mul: assert property (p_mul) else $error("product wrong");
	property p_ptr1_load;
		@(posedge i_clock) disable iff (i_srst) (i_op == crs_pkg::crs_op_load && i_dst == crs_pkg::crs_dst_ptr1) |=>
			o_pointer_reg_one == $past(i_operand_b);
	endproperty
	a_ptr1_load: assert property (p_ptr1_load) else $error("pointer one load wrong");
	property p_push_step;
		@(posedge i_clock) disable iff (i_srst) (i_op == crs_pkg::crs_op_push) |=>
			o_stack_ptr[6:0] == 7'($past(o_stack_ptr[6:0]) - 7'h01);
	endproperty
	a_push_step: assert property (p_push_step) else $error("push step wrong");
	property p_pop_step;
		@(posedge i_clock) disable iff (i_srst) (i_op == crs_pkg::crs_op_pop) |=>
			o_stack_ptr[6:0] == 7'($past(o_stack_ptr[6:0]) + 7'h01);
	endproperty
	a_pop_step: assert property (p_pop_step) else $error("pop step wrong");
	property p_call_frame;
		@(posedge i_clock) disable iff (i_srst) (i_op == crs_pkg::crs_op_call) |=>
			o_stack_ptr[6:0] == 7'($past(o_stack_ptr[6:0]) - 7'h02);
	endproperty
	a_call_frame: assert property (p_call_frame) else $error("call frame size wrong");
	property p_sp_reset;
		@(posedge i_clock) disable iff (i_srst)
			(i_op == crs_pkg::crs_op_reset_sp) |=> o_stack_ptr == 16'h017f;
	endproperty
	a_sp_reset: assert property (p_sp_reset) else $error("stack pointer not reset");
	property p_pc_load;
		@(posedge i_clock) disable iff (i_srst)
			i_pc_load |=> {o_instr_ptr_high, o_instr_ptr_low} == $past(i_pc_next);
	endproperty
	a_pc_load: assert property (p_pc_load) else $error("program counter not loaded");
	property p_pc_hold;
		@(posedge i_clock) disable iff (i_srst)
			!i_pc_load |=> $stable({o_instr_ptr_high, o_instr_ptr_low});
	endproperty
	a_pc_hold: assert property (p_pc_hold) else $error("program counter moved");
	property p_idle_keep;
		@(posedge i_clock) disable iff (i_srst) (i_op == crs_pkg::crs_op_none && i_dst == crs_pkg::crs_dst_none) |=>
			$stable(o_flags_register);
	endproperty
	a_idle_keep: assert property (p_idle_keep) else $error("idle cycle changed flags");
	c_mul: cover property (@(posedge i_clock) i_op == crs_pkg::crs_op_mul);
	c_entry: cover property (@(posedge i_clock) i_op == crs_pkg::crs_op_irq_entry ##2 i_op == crs_pkg::crs_op_irq_return);
	c_wrap: cover property (@(posedge i_clock) o_stack_ptr == 16'h0100 ##1 o_stack_ptr == 16'h017f);
	c_flag_load: cover property (@(posedge i_clock) i_op == crs_pkg::crs_op_load && flag_load_w);
	c_flag_write: cover property (@(posedge i_clock) i_op == crs_pkg::crs_op_flag_write);
endmodule

// ===== crs_core_regs_tb_top.sv
// self-checking testbench of the core register set
`timescale 1ns/1ns
module crs_core_regs_tb_top;
	logic i_clock = 1'b0;
	logic i_srst = 1'b1;
	crs_pkg::crs_op_type op;
	crs_pkg::crs_dst_type dst;
	logic [7:0] opa, opb, pop, wr, p1, p2, instr_ptr_low, instr_ptr_high, fl;
	logic [1:0] lvl, prio;
	logic pcld, fval, dis;
	logic [15:0] pcn, sp;
	logic [2:0] fidx;
	int errors = 0;
	int checks_done = 0;
	crs_core_regs dut (.i_clock(i_clock), .i_srst(i_srst), .i_op(op), .i_dst(dst), .i_operand_a(opa),
		.i_operand_b(opb), .i_irq_level(lvl), .i_pc_load(pcld), .i_pc_next(pcn), .i_flag_index(fidx),
		.i_flag_value(fval), .i_pop_data(pop), .o_work_reg(wr), .o_pointer_reg_one(p1),
		.o_pointer_reg_two(p2), .o_instr_ptr_low(instr_ptr_low), .o_instr_ptr_high(instr_ptr_high), .o_flags_register(fl),
		.o_stack_ptr(sp), .o_priority_level(prio), .o_irq_disabled(dis));
	crs_datapath_model model (.i_clock(i_clock), .o_op(op), .o_dst(dst), .o_operand_a(opa),
		.o_operand_b(opb), .o_irq_level(lvl), .o_pc_load(pcld), .o_pc_next(pcn), .o_flag_index(fidx),
		.o_flag_value(fval), .o_pop_data(pop));
	// 50 MHz clock
	always #10 i_clock = ~i_clock;
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		checks_done++;
		if (got !== exp) begin
			errors++;
			$display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// reset state of every register
	task automatic t_reset;
		chk({wr, fl}, 16'h00e8);
		chk({p1, p2}, 16'h0000);
		chk({instr_ptr_high, instr_ptr_low}, 16'h0000);
		chk(sp, 16'h017f);
		chk({13'h0, dis, prio}, 16'h0007);
	endtask
	// adds, carries out of the low nibble and the byte, subtract borrow
	task automatic t_arith;
		model.issue(crs_pkg::crs_op_add, crs_pkg::crs_dst_work, 8'h08, 8'h08, 8'h00);
		chk({wr, fl}, 16'h10f8);
		model.issue(crs_pkg::crs_op_add, crs_pkg::crs_dst_work, 8'h01, 8'h01, 8'h00);
		chk({wr, fl}, 16'h02e8);
		model.issue(crs_pkg::crs_op_add, crs_pkg::crs_dst_work, 8'hff, 8'h01, 8'h00);
		chk({wr, fl}, 16'h00fb);
		model.issue(crs_pkg::crs_op_adc, crs_pkg::crs_dst_work, 8'h0f, 8'h00, 8'h00);
		chk({wr, fl}, 16'h10f8);
		model.issue(crs_pkg::crs_op_sub, crs_pkg::crs_dst_work, 8'h00, 8'h01, 8'h00);
		chk({wr, fl}, 16'hfffd);
	endtask
	// moves into pointers, logic result zero keeps carry and nibble
	task automatic t_moves;
		model.issue(crs_pkg::crs_op_load, crs_pkg::crs_dst_ptr1, 8'h00, 8'h55, 8'h00);
		chk({p1, fl}, 16'h55f9);
		model.issue(crs_pkg::crs_op_load, crs_pkg::crs_dst_ptr2, 8'h00, 8'h80, 8'h00);
		chk({p2, fl}, 16'h80fd);
		model.issue(crs_pkg::crs_op_logic, crs_pkg::crs_dst_work, 8'hf0, 8'h0f, 8'h00);
		chk({wr, fl}, 16'h00fb);
	endtask
	// carry forcing, shift and bit test
	task automatic t_carry;
		model.issue(crs_pkg::crs_op_clear_carry, crs_pkg::crs_dst_none, 8'h00, 8'h00, 8'h00);
		chk({wr, fl}, 16'h00fa);
		model.issue(crs_pkg::crs_op_set_carry, crs_pkg::crs_dst_none, 8'h00, 8'h00, 8'h00);
		chk({wr, fl}, 16'h00fb);
		model.issue(crs_pkg::crs_op_shift, crs_pkg::crs_dst_work, 8'h40, 8'h00, 8'h00);
		chk({wr, fl}, 16'h80fc);
		model.issue(crs_pkg::crs_op_btjt, crs_pkg::crs_dst_none, 8'h04, 8'h00, 8'h02);
		chk({wr, fl}, 16'h80fd);
		model.issue(crs_pkg::crs_op_btjt, crs_pkg::crs_dst_none, 8'h00, 8'h00, 8'h02);
		chk({wr, fl}, 16'h80fc);
		model.issue(crs_pkg::crs_op_mul, crs_pkg::crs_dst_none, 8'h10, 8'h10, 8'h00);
		chk({wr, p1}, 16'h0001);
	endtask
	// priority writes, entry at every level and return that leaves pointer two alone
	task automatic t_prio;
		model.issue(crs_pkg::crs_op_irq_mask, crs_pkg::crs_dst_none, 8'h00, 8'h00, 8'h00);
		chk({13'h0, dis, prio}, 16'h0007);
		model.issue(crs_pkg::crs_op_irq_unmask, crs_pkg::crs_dst_none, 8'h00, 8'h00, 8'h00);
		chk({12'h0, fl[5], fl[3], dis, prio[0]}, 16'h0008);
		model.issue(crs_pkg::crs_op_irq_mask, crs_pkg::crs_dst_none, 8'h00, 8'h00, 8'h00);
		model.issue(crs_pkg::crs_op_halt, crs_pkg::crs_dst_none, 8'h00, 8'h00, 8'h00);
		chk({14'h0, prio}, 16'h0002);
		model.issue(crs_pkg::crs_op_irq_mask, crs_pkg::crs_dst_none, 8'h00, 8'h00, 8'h00);
		model.issue(crs_pkg::crs_op_wait_irq, crs_pkg::crs_dst_none, 8'h00, 8'h00, 8'h00);
		chk({14'h0, prio}, 16'h0002);
		for (int l = 0; l < 4; l++) begin
			model.issue(crs_pkg::crs_op_irq_entry, crs_pkg::crs_dst_none, 8'h00, 8'h00, 8'(l));
			chk({13'h0, dis, prio}, 16'(l) | ((l == 3) ? 16'h4 : 16'h0));
			chk({p2, sp[7:0]}, 16'h807a);
			model.issue(crs_pkg::crs_op_irq_return, crs_pkg::crs_dst_none, 8'h11, 8'h22, 8'h20);
			chk({wr, p1}, 16'h1122);
			chk({p2, fl}, 16'h80e0);
			chk(sp, 16'h017f);
		end
		model.issue(crs_pkg::crs_op_push_flags, crs_pkg::crs_dst_none, 8'h00, 8'h00, 8'h00);
		model.issue(crs_pkg::crs_op_pop_flags, crs_pkg::crs_dst_none, 8'h00, 8'h00, 8'h0b);
		chk({fl, 6'h0, prio}, 16'hcb01);
	endtask
	// stack steps and silent wrap at both ends
	task automatic t_stack;
		model.issue(crs_pkg::crs_op_push, crs_pkg::crs_dst_none, 8'h00, 8'h00, 8'h00);
		chk(sp, 16'h017e);
		model.issue(crs_pkg::crs_op_pop, crs_pkg::crs_dst_none, 8'h00, 8'h00, 8'h00);
		model.issue(crs_pkg::crs_op_pop, crs_pkg::crs_dst_none, 8'h00, 8'h00, 8'h00);
		chk(sp, 16'h0100);
		model.issue(crs_pkg::crs_op_push, crs_pkg::crs_dst_none, 8'h00, 8'h00, 8'h00);
		chk(sp, 16'h017f);
		model.issue(crs_pkg::crs_op_call, crs_pkg::crs_dst_none, 8'h00, 8'h00, 8'h00);
		chk(sp, 16'h017d);
		model.issue(crs_pkg::crs_op_ret, crs_pkg::crs_dst_none, 8'h00, 8'h00, 8'h00);
		chk(sp, 16'h017f);
		model.issue(crs_pkg::crs_op_call, crs_pkg::crs_dst_none, 8'h00, 8'h00, 8'h00);
		model.issue(crs_pkg::crs_op_reset_sp, crs_pkg::crs_dst_none, 8'h00, 8'h00, 8'h00);
		chk(sp, 16'h017f);
	endtask
	// program counter halves and single flag writes, fixed ones stay set
	task automatic t_pc_bits;
		model.jump(16'h1234);
		chk({instr_ptr_high, instr_ptr_low}, 16'h1234);
		model.jump(16'hfedc);
		chk({instr_ptr_high, instr_ptr_low}, 16'hfedc);
		model.issue(crs_pkg::crs_op_flag_write, crs_pkg::crs_dst_none, 8'h00, 8'h00, 8'h01);
		model.issue(crs_pkg::crs_op_flag_write, crs_pkg::crs_dst_none, 8'h00, 8'h00, 8'h84);
		model.issue(crs_pkg::crs_op_flag_write, crs_pkg::crs_dst_none, 8'h00, 8'h00, 8'h07);
		chk({8'h00, fl}, 16'h00d9);
		model.issue(crs_pkg::crs_op_load, crs_pkg::crs_dst_flags, 8'h00, 8'h21, 8'h00);
		chk({fl, 6'h0, prio}, 16'he102);
	endtask
	task automatic complete_run;
		if (errors == 0 && checks_done > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	// the whole sequence needs about 110 cycles; a hang is cut at 5000 cycles, well past that
	initial begin
		#100000;
		errors++;
		complete_run();
	end
	initial begin
		repeat (16) @(posedge i_clock);
		i_srst <= 1'b0;
		#1;
		t_reset();
		t_arith();
		t_moves();
		t_carry();
		t_prio();
		t_stack();
		t_pc_bits();
		// a second reset after the last test must bring back the same state
		@(posedge i_clock);
		i_srst <= 1'b1;
		repeat (2) @(posedge i_clock);
		i_srst <= 1'b0;
		#1;
		t_reset();
		complete_run();
	end
endmodule

// ===== crs_datapath_model.sv
// behavioural model of the instruction datapath and interrupt sequencer feeding the register set
`timescale 1ns/1ns
module crs_datapath_model (
	input wire logic i_clock,
	output crs_pkg::crs_op_type o_op,
	output crs_pkg::crs_dst_type o_dst,
	output logic [7:0] o_operand_a,
	output logic [7:0] o_operand_b,
	output logic [1:0] o_irq_level,
	output logic o_pc_load,
	output logic [15:0] o_pc_next,
	output logic [2:0] o_flag_index,
	output logic o_flag_value,
	output logic [7:0] o_pop_data
);
	// idle values from time zero so that no input of the register set floats
	initial begin
		o_op = crs_pkg::crs_op_none;
		o_dst = crs_pkg::crs_dst_none;
		o_operand_a = 8'h00;
		o_operand_b = 8'h00;
		o_irq_level = 2'h0;
		o_pc_load = 1'b0;
		o_pc_next = 16'h0000;
		o_flag_index = 3'h0;
		o_flag_value = 1'b0;
		o_pop_data = 8'h00;
	end
	// one operation per call; aux carries level, flag index/value or the popped byte
	// operands are inverted once taken, so a block that samples late sees junk rather than a stale match
	task automatic issue(input crs_pkg::crs_op_type op, input crs_pkg::crs_dst_type dst,
		input logic [7:0] a, input logic [7:0] b, input logic [7:0] aux);
		@(posedge i_clock);
		o_op <= op;
		o_dst <= dst;
		o_operand_a <= a;
		o_operand_b <= b;
		o_irq_level <= aux[1:0];
		o_flag_index <= aux[2:0];
		o_flag_value <= aux[7];
		o_pop_data <= aux;
		@(posedge i_clock);
		o_op <= crs_pkg::crs_op_none;
		o_dst <= crs_pkg::crs_dst_none;
		o_operand_a <= ~a;
		o_operand_b <= ~b;
		o_pop_data <= ~aux;
		#1;
	endtask
	// program counter jump, held for exactly one taking edge
	task automatic jump(input logic [15:0] pc);
		@(posedge i_clock);
		o_pc_load <= 1'b1;
		o_pc_next <= pc;
		@(posedge i_clock);
		o_pc_load <= 1'b0;
		o_pc_next <= ~pc;
		#1;
	endtask
endmodule

// ===== crs_pkg.sv
// package with the layout, reset values and operation codes of the core register set
package crs_pkg;
	localparam int unsigned crs_data_width = 8;
	localparam int unsigned crs_addr_width = 16;
	// flag register bit positions
	localparam int unsigned crs_bit_one7 = 7;
	localparam int unsigned crs_bit_one6 = 6;
	localparam int unsigned crs_bit_prio_high = 5;
	localparam int unsigned crs_bit_nibble_carry = 4;
	localparam int unsigned crs_bit_prio_low = 3;
	localparam int unsigned crs_bit_msb_copy = 2;
	localparam int unsigned crs_bit_null = 1;
	localparam int unsigned crs_bit_overflow = 0;
	// reset pattern 111x1xxx, undefined bits taken as zero
	localparam logic [7:0] crs_flags_reset = 8'he8;
	localparam logic [7:0] crs_flags_fixed_ones = 8'hc0;
	localparam logic [7:0] crs_work_reset = 8'h00;
	localparam logic [7:0] crs_ptr_reset = 8'h00;
	localparam logic [15:0] crs_pc_reset = 16'h0000;
	// stack pointer: upper byte forced, 128 byte deep
	localparam logic [15:0] crs_sp_reset = 16'h017f;
	localparam logic [7:0] crs_sp_high = 8'h01;
	localparam logic [7:0] crs_sp_top = 8'h7f;
	localparam logic [7:0] crs_sp_bottom = 8'h00;
	localparam int unsigned crs_irq_frame_bytes = 5;
	localparam int unsigned crs_call_frame_bytes = 2;
	// priority encodings {high,low}
	localparam logic [1:0] crs_prio_level0 = 2'h2;
	localparam logic [1:0] crs_prio_level1 = 2'h1;
	localparam logic [1:0] crs_prio_level2 = 2'h0;
	localparam logic [1:0] crs_prio_level3 = 2'h3;
	// operations issued by the datapath
	typedef enum logic [4:0] {
		crs_op_none,
		crs_op_add,
		crs_op_adc,
		crs_op_sub,
		crs_op_logic,
		crs_op_load,
		crs_op_shift,
		crs_op_btjt,
		crs_op_set_carry,
		crs_op_clear_carry,
		crs_op_mul,
		crs_op_irq_unmask,
		crs_op_irq_mask,
		crs_op_irq_entry,
		crs_op_irq_return,
		crs_op_halt,
		crs_op_wait_irq,
		crs_op_push_flags,
		crs_op_pop_flags,
		crs_op_flag_write,
		crs_op_call,
		crs_op_ret,
		crs_op_push,
		crs_op_pop,
		crs_op_reset_sp
	} crs_op_type;
	// register destination of a result
	typedef enum logic [2:0] {
		crs_dst_none,
		crs_dst_work,
		crs_dst_ptr1,
		crs_dst_ptr2,
		crs_dst_flags
	} crs_dst_type;
endpackage
